//--- core/acr_pkg.sv
/*
  Constants shared by the converter control block: register offsets, field
  positions, reset values and timing counts.
  Assumes an 8-bit register port clocked by the 20 MHz instruction clock.
*/
package acr_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] ACR_OFS_MODE   = 8'h10;
  localparam logic [7:0] ACR_OFS_CLKFLG = 8'h11;
  localparam logic [7:0] ACR_OFS_RESHI  = 8'h12;
  localparam logic [7:0] ACR_OFS_REFSEL = 8'h13;
  localparam logic [7:0] ACR_OFS_SMPRES = 8'h14;
  localparam logic [7:0] ACR_OFS_PINSEL = 8'h16;

  // Mode register field positions.
  localparam int ACR_MODE_ON    = 7;
  localparam int ACR_MODE_START = 6;
  localparam int ACR_MODE_DONE  = 5;
  localparam int ACR_MODE_GEN   = 4;

  // Clock and flag register field positions.
  localparam int ACR_CF_IRQF = 7;
  localparam int ACR_CF_IRQE = 6;

  // Reference select field position.
  localparam int ACR_REF_EXT = 7;

  // Reset values of the writable fields.
  localparam logic [3:0] ACR_RST_CHAN   = 4'h0;
  localparam logic [1:0] ACR_RST_CKDIV  = 2'h0;
  localparam logic [1:0] ACR_RST_REFLVL = 2'h3;
  localparam logic [1:0] ACR_RST_SMP    = 2'h2;
  localparam logic [1:0] ACR_RST_RES    = 2'h2;
  localparam logic [7:0] ACR_RST_PINSEL = 8'h00;
  localparam logic [2:0] ACR_RST_PBHI   = 3'h0;

  // Channel codes.
  localparam logic [3:0] ACR_CH_PB0    = 4'h5;
  localparam logic [3:0] ACR_CH_QUART  = 4'hB;

  // Clock divider ratios per code.
  localparam logic [4:0] ACR_DIV_16 = 5'h10;
  localparam logic [4:0] ACR_DIV_8  = 5'h08;
  localparam logic [4:0] ACR_DIV_1  = 5'h01;
  localparam logic [4:0] ACR_DIV_2  = 5'h02;

  // Converter clocks per conversion beyond sampling: one per result bit.
  localparam logic [3:0] ACR_BITS_8  = 4'h8;
  localparam logic [3:0] ACR_BITS_10 = 4'hA;
  localparam logic [3:0] ACR_BITS_12 = 4'hC;

endpackage

//--- core/acr_clkdiv.sv
/*
  Converter clock enable divider: one-cycle pulse every ratio cycles.
  Assumes a single clock; ratio may change at any time and takes effect without restarting the count.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_clkdiv
  import acr_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Control.
  input  wire logic       run,
  input  wire logic [4:0] ratio,
  // Enable pulse.
  output logic            tick
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  wire        wrap = (cnt_reg >= ratio - 5'h01);

  // Count up to ratio minus one, then pulse and wrap.
  assign cnt_next = (!run || wrap) ? 5'h00 : cnt_reg + 5'h01;
  assign tick     = run && wrap;

  // Holding the counter at zero when idle gives every conversion the same
  // phase, at the cost of the first converter clock arriving ratio minus one cycles late.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

//--- core/acr_ctrl.sv
/*
  Register front end and sequencer for a successive-approximation converter.
  Holds the control registers, routes the input mux, counts the sampling and
  conversion phases on a divided clock, captures the result and raises the
  completion flag. Assumes the analog core delivers its code on conv_data
  when the sequence ends, and that registers are reached over a one-cycle
  strobe port with read data one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl
  import acr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Analog core.
  input  wire logic [11:0] conv_data,
  output logic             conv_power,
  output logic             conv_clk_en,
  output logic             conv_sample,
  output logic      [3:0]  conv_bits,
  output logic      [10:0] conv_pad_sel,
  output logic             conv_quarter_sel,
  output logic             conv_ref_ext,
  output logic      [1:0]  conv_ref_level,
  // Pads.
  output logic      [4:0]  porta_analog_only,
  output logic      [5:0]  portb_analog_only,
  // Interrupt.
  output logic             irq
);

  typedef enum logic [1:0] {ACR_IDLE, ACR_SAMPLE, ACR_CONVERT} acr_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic        converter_on_reg;
  logic        input_mux_global_enable_reg;
  logic [3:0]  input_channel_select_reg;
  logic        conv_done_reg;
  logic        conversion_irq_flag_reg;
  logic        conversion_irq_enable_reg;
  logic [1:0]  converter_clock_divider_reg;
  logic [3:0]  result_low_nibble_reg;
  logic [7:0]  result_high_byte_reg;
  logic        external_reference_select_reg;
  logic [1:0]  internal_reference_level_reg;
  logic [2:0]  portb_hi_analog_reg;
  logic [1:0]  sample_pulse_width_reg;
  logic [1:0]  resolution_select_reg;
  logic [7:0]  analog_pin_select_reg;
  logic [7:0]  rdata_reg;
  acr_state_t  state_reg;
  acr_state_t  state_next;
  logic [3:0]  phase_cnt_reg;
  logic [3:0]  phase_cnt_next;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire wr_mode   = reg_wr && (reg_addr == ACR_OFS_MODE);
  wire wr_clkflg = reg_wr && (reg_addr == ACR_OFS_CLKFLG);
  wire wr_refsel = reg_wr && (reg_addr == ACR_OFS_REFSEL);
  wire wr_smpres = reg_wr && (reg_addr == ACR_OFS_SMPRES);
  wire wr_pinsel = reg_wr && (reg_addr == ACR_OFS_PINSEL);
  wire start_req = wr_mode && reg_wdata[ACR_MODE_START]
                   && converter_on_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Converter clock divider and phase lengths.

  logic [4:0] div_ratio;
  logic       conv_tick;
  logic [3:0] sample_len;

  // Divider ratio per clock code.
  assign div_ratio = (converter_clock_divider_reg == 2'h0) ? ACR_DIV_16 :
                     (converter_clock_divider_reg == 2'h1) ? ACR_DIV_8  :
                     (converter_clock_divider_reg == 2'h2) ? ACR_DIV_1  :
                                                             ACR_DIV_2;

  // Sampling length doubles per code step: 1, 2, 4, 8 converter clocks.
  assign sample_len = 4'h1 << sample_pulse_width_reg;

  // Bits resolved per conversion; the upper resolution bit alone means 12.
  assign conv_bits = resolution_select_reg[1]    ? ACR_BITS_12 :
                     resolution_select_reg[0]    ? ACR_BITS_10 :
                                                   ACR_BITS_8;

  acr_clkdiv u_div (
    .clk   (clk),
    .srst  (srst),
    .run   (state_reg != ACR_IDLE),
    .ratio (div_ratio),
    .tick  (conv_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  wire phase_end = conv_tick && (phase_cnt_reg == 4'h1);
  wire conv_end  = (state_reg == ACR_CONVERT) && phase_end;

  // Sample, then one converter clock per bit; turning the converter off
  // abandons a conversion, so done stays low until a later conversion completes.
  always_comb begin
    state_next     = state_reg;
    phase_cnt_next = phase_cnt_reg;
    case (state_reg)
      ACR_IDLE: begin
        if (start_req) begin
          state_next     = ACR_SAMPLE;
          phase_cnt_next = sample_len;
        end
      end
      ACR_SAMPLE: begin
        if (phase_end) begin
          state_next     = ACR_CONVERT;
          phase_cnt_next = conv_bits;
        end else if (conv_tick) begin
          phase_cnt_next = phase_cnt_reg - 4'h1;
        end
      end
      ACR_CONVERT: begin
        if (phase_end) begin
          state_next = ACR_IDLE;
        end else if (conv_tick) begin
          phase_cnt_next = phase_cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = ACR_IDLE;
      end
    endcase
    if (!converter_on_reg) begin
      state_next = ACR_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= ACR_IDLE;
      phase_cnt_reg <= 4'h0;
    end else begin
      state_reg     <= state_next;
      phase_cnt_reg <= phase_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result capture, done bit and interrupt flag.

  // Result and done land on the same edge, so software never sees done
  // with stale data.
  always_ff @(posedge clk) begin
    if (srst) begin
      result_high_byte_reg  <= 8'h00;
      result_low_nibble_reg <= 4'h0;
      conv_done_reg         <= 1'b1;
    end else begin
      if (conv_end) begin
        result_high_byte_reg  <= conv_data[11:4];
        result_low_nibble_reg <= conv_data[3:0];
      end
      if (start_req) begin
        conv_done_reg <= 1'b0;
      end else if (conv_end) begin
        conv_done_reg <= 1'b1;
      end
    end
  end

  // Set wins over a software clear in the same cycle.
  wire flag_clr = wr_clkflg && !reg_wdata[ACR_CF_IRQF];
  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_irq_flag_reg <= 1'b0;
    end else if (conv_end) begin
      conversion_irq_flag_reg <= 1'b1;
    end else if (flag_clr) begin
      conversion_irq_flag_reg <= 1'b0;
    end
  end

  assign irq = conversion_irq_flag_reg && conversion_irq_enable_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Writable control registers.

  always_ff @(posedge clk) begin
    if (srst) begin
      converter_on_reg            <= 1'b0;
      input_mux_global_enable_reg <= 1'b0;
      input_channel_select_reg    <= ACR_RST_CHAN;
    end else if (wr_mode) begin
      converter_on_reg            <= reg_wdata[ACR_MODE_ON];
      input_mux_global_enable_reg <= reg_wdata[ACR_MODE_GEN];
      input_channel_select_reg    <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_irq_enable_reg   <= 1'b0;
      converter_clock_divider_reg <= ACR_RST_CKDIV;
    end else if (wr_clkflg) begin
      conversion_irq_enable_reg   <= reg_wdata[ACR_CF_IRQE];
      converter_clock_divider_reg <= reg_wdata[5:4];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      external_reference_select_reg <= 1'b0;
      internal_reference_level_reg  <= ACR_RST_REFLVL;
    end else if (wr_refsel) begin
      external_reference_select_reg <= reg_wdata[ACR_REF_EXT];
      internal_reference_level_reg  <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      portb_hi_analog_reg    <= ACR_RST_PBHI;
      sample_pulse_width_reg <= ACR_RST_SMP;
      resolution_select_reg  <= ACR_RST_RES;
    end else if (wr_smpres) begin
      portb_hi_analog_reg    <= reg_wdata[6:4];
      sample_pulse_width_reg <= reg_wdata[3:2];
      resolution_select_reg  <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      analog_pin_select_reg <= ACR_RST_PINSEL;
    end else if (wr_pinsel) begin
      analog_pin_select_reg <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero.

  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == ACR_OFS_MODE)   ? {converter_on_reg, 1'b0, conv_done_reg,
                                    input_mux_global_enable_reg,
                                    input_channel_select_reg} :
    (reg_addr == ACR_OFS_CLKFLG) ? {conversion_irq_flag_reg,
                                    conversion_irq_enable_reg,
                                    converter_clock_divider_reg,
                                    result_low_nibble_reg} :
    (reg_addr == ACR_OFS_RESHI)  ? result_high_byte_reg :
    (reg_addr == ACR_OFS_REFSEL) ? {external_reference_select_reg, 5'h00,
                                    internal_reference_level_reg} :
    (reg_addr == ACR_OFS_SMPRES) ? {1'b0, portb_hi_analog_reg,
                                    sample_pulse_width_reg,
                                    resolution_select_reg} :
    (reg_addr == ACR_OFS_PINSEL) ? analog_pin_select_reg : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end
  assign reg_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Analog controls.

  wire [15:0] chan_onehot = 16'h0001 << input_channel_select_reg;
  wire        mux_live    = input_mux_global_enable_reg && converter_on_reg;

  // Pad selects are one-hot; a code above the quarter-supply tap connects
  // nothing, which is safer than aliasing onto a pad.
  assign conv_pad_sel     = mux_live ? chan_onehot[10:0] : 11'h000;
  assign conv_quarter_sel = mux_live
                            && (input_channel_select_reg == ACR_CH_QUART);
  assign conv_power       = converter_on_reg;
  assign conv_clk_en      = conv_tick;
  assign conv_sample      = (state_reg == ACR_SAMPLE);
  assign conv_ref_ext     = external_reference_select_reg;
  assign conv_ref_level   = internal_reference_level_reg;
  assign porta_analog_only = analog_pin_select_reg[4:0];
  assign portb_analog_only = {portb_hi_analog_reg,
                              analog_pin_select_reg[7:5]};

endmodule
`default_nettype wire

//--- dv/acr_ctrl_props.sv
/*
  Concurrent checks for the converter control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_props
  import acr_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Register port.
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Converter side.
  input wire logic        conv_power,
  input wire logic        conv_clk_en,
  input wire logic        conv_sample,
  input wire logic [3:0]  conv_bits,
  input wire logic [10:0] conv_pad_sel,
  input wire logic        conv_quarter_sel,
  input wire logic        conv_ref_ext,
  input wire logic [1:0]  conv_ref_level,
  input wire logic [4:0]  porta_analog_only,
  input wire logic [5:0]  portb_analog_only,
  input wire logic        irq
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Write decodes, named so each property reads as its cause.
  wire logic wr_mode = reg_wr && reg_addr == ACR_OFS_MODE;
  wire logic wr_cf   = reg_wr && reg_addr == ACR_OFS_CLKFLG;
  wire logic wr_ref  = reg_wr && reg_addr == ACR_OFS_REFSEL;
  wire logic wr_smp  = reg_wr && reg_addr == ACR_OFS_SMPRES;
  wire logic wr_pin  = reg_wr && reg_addr == ACR_OFS_PINSEL;

  // Each check below except a_start_rd, a_pad_off, a_off_idle and a_irq_hold ties an output to the write that caused it.
  property p_power;
    wr_mode |=> conv_power == $past(reg_wdata[ACR_MODE_ON]);
  endproperty
  a_power: assert property (p_power)
    else $error("power does not follow the on bit");
  property p_start_rd;
    reg_rd && reg_addr == ACR_OFS_MODE |=> !reg_rdata[ACR_MODE_START];
  endproperty
  a_start_rd: assert property (p_start_rd)
    else $error("start bit read back as one");
  property p_pad_off;
    !conv_power |-> conv_pad_sel == 11'h000 && !conv_quarter_sel;
  endproperty
  a_pad_off: assert property (p_pad_off)
    else $error("input connected while converter is off");
  // A powered-down converter must neither sample nor see converter clocks.
  property p_off_idle;
    !conv_power |-> !conv_sample && !conv_clk_en;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converter sequenced while switched off");
  property p_pad_map;
    wr_mode && reg_wdata[7] && reg_wdata[4] |=>
      {conv_quarter_sel, conv_pad_sel} == 12'(12'h001 << $past(reg_wdata[3:0]));
  endproperty
  a_pad_map: assert property (p_pad_map)
    else $error("input mux does not match channel code");
  property p_irq_mask;
    wr_cf && !reg_wdata[ACR_CF_IRQE] |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised while disabled");
  property p_irq_hold;
    irq && !wr_cf |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without software clear");
  property p_bits;
    wr_smp |=> conv_bits == ($past(reg_wdata[1]) ? ACR_BITS_12 :
                             $past(reg_wdata[0]) ? ACR_BITS_10 : ACR_BITS_8);
  endproperty
  a_bits: assert property (p_bits)
    else $error("resolution does not follow its field");
  property p_ref;
    wr_ref |=> conv_ref_ext == $past(reg_wdata[7]) &&
               conv_ref_level == $past(reg_wdata[1:0]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference outputs do not follow the register");
  property p_analog;
    wr_pin |=> porta_analog_only == $past(reg_wdata[4:0]) &&
               portb_analog_only[2:0] == $past(reg_wdata[7:5]);
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog-only pins do not follow the register");
endmodule
`default_nettype wire

//--- dv/acr_ctrl_test.sv
/*
  Self-checking bench for the converter control block.
  Drives the register port and converter code itself; checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_test
  import acr_pkg::*;
;
  logic        clk, srst, reg_wr, reg_rd, conv_power, conv_clk_en;
  logic        conv_sample, conv_quarter_sel, conv_ref_ext, irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, v;
  logic [11:0] conv_data;
  logic [3:0]  conv_bits;
  logic [10:0] conv_pad_sel;
  logic [1:0]  conv_ref_level;
  logic [4:0]  porta_analog_only;
  logic [5:0]  portb_analog_only;
  int          err_count, n_checks;
  logic [7:0]  rst_exp [8] = '{8'h20, 8'h00, 8'h00, 8'h03, 8'h0A, 8'h00,
                               8'h00, 8'h00};

  acr_ctrl uut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_data(conv_data), .conv_power(conv_power),
    .conv_clk_en(conv_clk_en), .conv_sample(conv_sample),
    .conv_bits(conv_bits), .conv_pad_sel(conv_pad_sel),
    .conv_quarter_sel(conv_quarter_sel), .conv_ref_ext(conv_ref_ext),
    .conv_ref_level(conv_ref_level), .porta_analog_only(porta_analog_only),
    .portb_analog_only(portb_analog_only), .irq(irq));

  // The 20 MHz instruction clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and expectations.
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // An idle cycle after each strobe keeps a strobe from being set twice.
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  function automatic int ratio(input logic [1:0] c);
    return (c == 2'h0) ? 16 : (c == 2'h1) ? 8 : (c == 2'h2) ? 1 : 2;
  endfunction
  function automatic int nbits(input logic [1:0] r);
    return r[1] ? 12 : r[0] ? 10 : 8;
  endfunction
  // One conversion timed from its start write to the interrupt.
  task automatic conv(input logic [1:0] ck, sp, rs);
    int len, n;
    realtime t0;
    len = ratio(ck) * ((1 << sp) + nbits(rs));
    conv_data <= 12'($urandom);
    wr(ACR_OFS_CLKFLG, {2'h1, ck, 4'h0});
    wr(ACR_OFS_SMPRES, {4'h0, sp, rs});
    wr(ACR_OFS_MODE, 8'h80);
    wr(ACR_OFS_MODE, 8'hC0);
    t0 = $realtime;
    rd(ACR_OFS_MODE);
    chk(d, 12'h080);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    if (irq !== 1'b1) begin
      err_count++;
      finish_test();
    end
    n = int'(($realtime - t0 + 25.0) / 50.0);
    chk(12'(n >= len && n <= len + ratio(ck) + 1), 12'h001);
    @(posedge clk);
    rd(ACR_OFS_MODE);
    chk(d, 12'h0A0);
    rd(ACR_OFS_RESHI);
    chk(d, {4'h0, conv_data[11:4]});
    rd(ACR_OFS_CLKFLG);
    chk(d, {4'h0, 2'h3, ck, conv_data[3:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, fields, mux, conversions, interrupt.
  initial begin
    // Reset sits in the top bit of this 31-bit group; every strobe starts low.
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, conv_data} = 31'h40000000;
    err_count = 0;
    n_checks  = 0;
    void'($urandom(32'h37046AFA));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({irq, conv_power, conv_ref_level, conv_bits}, 12'h03C);
    wr(ACR_OFS_RESHI, 8'hFF);
    wr(8'h15, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(8'h10 + 8'(a));
      chk(d, rst_exp[a]);
    end
    repeat (6) begin
      v = 8'($urandom);
      wr(ACR_OFS_REFSEL, v);
      wr(ACR_OFS_SMPRES, v);
      wr(ACR_OFS_PINSEL, v);
      rd(ACR_OFS_REFSEL);
      chk(d, v & 8'h83);
      rd(ACR_OFS_SMPRES);
      chk(d, v & 8'h7F);
      chk({conv_ref_ext, conv_ref_level, conv_bits}, {v[7], v[1:0], 4'(nbits(v[1:0]))});
      chk({portb_analog_only, porta_analog_only}, {v[6:4], v});
    end
    for (int c = 0; c < 16; c++) begin
      wr(ACR_OFS_MODE, {4'h9, 4'(c)});
      chk({conv_quarter_sel, conv_pad_sel}, 12'(12'h001 << c));
    end
    wr(ACR_OFS_MODE, 8'h85);
    chk({conv_quarter_sel, conv_pad_sel}, 12'h000);
    rd(ACR_OFS_MODE);
    chk(d, 12'h0A5);
    conv(2'h2, 2'h0, 2'h0);
    conv(2'h0, 2'h3, 2'h3);
    for (int i = 0; i < 8; i++) conv(2'(i), 2'($urandom), 2'($urandom));
    // Masking hides a pending flag; only a written zero clears it.
    wr(ACR_OFS_CLKFLG, 8'h80);
    chk(irq, 12'h000);
    wr(ACR_OFS_CLKFLG, 8'hC0);
    chk(irq, 12'h001);
    wr(ACR_OFS_CLKFLG, 8'h40);
    chk(irq, 12'h000);
    wr(ACR_OFS_MODE, 8'h00);
    wr(ACR_OFS_MODE, 8'h40);
    rd(ACR_OFS_MODE);
    chk({conv_power, d}, 12'h020);
    finish_test();
  end
endmodule

bind acr_ctrl acr_ctrl_props u_props (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_power(conv_power),
  .conv_clk_en(conv_clk_en), .conv_sample(conv_sample),
  .conv_bits(conv_bits), .conv_pad_sel(conv_pad_sel),
  .conv_quarter_sel(conv_quarter_sel), .conv_ref_ext(conv_ref_ext),
  .conv_ref_level(conv_ref_level), .porta_analog_only(porta_analog_only),
  .portb_analog_only(portb_analog_only), .irq(irq));
`default_nettype wire
